// File: logic/stw_timeout_ctl.sv
// The strobed register port was decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "stw_cfg.svh"
module stw_timeout_ctl
   import stw_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_resetn,
   input wire logic i_fund_resetn,
   input wire logic i_ce,
   input wire logic [11:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic [2:0] i_timeout_status_reg,
   input wire logic [2:0] i_discard,
   input wire logic i_wake_req,
   input wire logic i_beacon_req,
   output logic o_timeout_discard_enable,
   output logic o_err_cor,
   output logic o_err_nonfatal,
   output logic o_err_fatal,
   output logic o_wake_sideband_n,
   output logic o_beacon,
   output logic o_irq
);

   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic stw_count_t sat_inc(input stw_count_t c, input logic inc);
      if (inc && c != `STW_CNT_MAX) begin
         sat_inc = c + 8'h01;
      end else begin
         sat_inc = c;
      end
   endfunction

   function automatic logic [2:0] rep_decode(input logic [1:0] sel);
      case (stw_report_e'(sel))
         STW_REP_COR: rep_decode = 3'b001;
         STW_REP_NONFATAL: rep_decode = 3'b010;
         STW_REP_FATAL: rep_decode = 3'b100;
         default: rep_decode = 3'b000;
      endcase
   endfunction

   logic [1:0] posted_timeout_report_sel;
   logic [1:0] nonposted_timeout_report_sel;
   logic [1:0] completion_timeout_report_sel;
   stw_count_t posted_discard_counter;
   stw_count_t nonposted_discard_counter;
   stw_count_t completion_discard_counter;
   logic wake_output_enable;
   logic beacon_enable;
   logic timeout_discard_enable;
   logic [2:0] status_q;
   logic [2:0] irq_status;
   logic [2:0] irq_mask;
   logic [2:0] status_rise;
   logic [2:0] next_err;
   logic cnt_read;
   logic [2:0] disc_seen;
   logic [2:0] disc_seen_q;
   logic [31:0] next_rdata;

   wire wr_rep = i_ce && i_wr && i_addr == `STW_OFS_REPORT_CTL;
   wire wr_wake = i_ce && i_wr && i_addr == `STW_OFS_WAKEUP_CTL;
   wire wr_to = i_ce && i_wr && i_addr == `STW_OFS_TIMEOUT_CTL;
   wire wr_ist = i_ce && i_wr && i_addr == `STW_OFS_IRQ_STATUS;
   wire wr_imk = i_ce && i_wr && i_addr == `STW_OFS_IRQ_MASK;
   assign cnt_read = i_ce && i_rd && i_addr == `STW_OFS_DISCARD_CNT;

   // ----------------------------------------
   // Sticky control fields
   // ----------------------------------------
   // Sticky: only the fundamental reset restores defaults
   always_ff @(posedge i_core_clk) begin
      if (!i_fund_resetn) begin
         posted_timeout_report_sel <= `STW_RST_POSTED_SEL;
         nonposted_timeout_report_sel <= `STW_RST_NONPOSTED_SEL;
         completion_timeout_report_sel <= `STW_RST_COMPL_SEL;
         timeout_discard_enable <= `STW_RST_TO_EN;
      end else if (wr_rep) begin
         posted_timeout_report_sel <= i_wdata[1:0];
         nonposted_timeout_report_sel <= i_wdata[3:2];
         completion_timeout_report_sel <= i_wdata[5:4];
      end else if (wr_to) begin
         timeout_discard_enable <= i_wdata[0];
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_fund_resetn) begin
         wake_output_enable <= `STW_RST_WAKE_EN;
         beacon_enable <= `STW_RST_BEACON_EN;
      end else if (wr_wake) begin
         wake_output_enable <= i_wdata[0];
         beacon_enable <= i_wdata[1];
      end
   end

   // Queue timers sit outside; this enable steers their discard
   assign o_timeout_discard_enable = timeout_discard_enable;
   assign disc_seen = i_discard & {3{timeout_discard_enable}};

   // ----------------------------------------
   // Discard counters
   // ----------------------------------------
   // A discard on the read cycle lands as 1 so no event is lost
   always_ff @(posedge i_core_clk) begin
      if (!i_fund_resetn) begin
         posted_discard_counter <= 8'h00;
         nonposted_discard_counter <= 8'h00;
         completion_discard_counter <= 8'h00;
      end else if (i_ce) begin
         posted_discard_counter <= sat_inc(cnt_read ? 8'h00 : posted_discard_counter, disc_seen[0]);
         nonposted_discard_counter <= sat_inc(cnt_read ? 8'h00 : nonposted_discard_counter, disc_seen[1]);
         completion_discard_counter <= sat_inc(cnt_read ? 8'h00 : completion_discard_counter, disc_seen[2]);
      end
   end

   // ----------------------------------------
   // Error message reporting
   // ----------------------------------------
   assign status_rise = i_timeout_status_reg & ~status_q;

   always_comb begin
      next_err = 3'b000;
      if (status_rise[0]) next_err = next_err | rep_decode(posted_timeout_report_sel);
      if (status_rise[1]) next_err = next_err | rep_decode(nonposted_timeout_report_sel);
      if (status_rise[2]) next_err = next_err | rep_decode(completion_timeout_report_sel);
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         status_q <= 3'b000;
         o_err_cor <= 1'b0;
         o_err_nonfatal <= 1'b0;
         o_err_fatal <= 1'b0;
      end else if (i_ce) begin
         status_q <= i_timeout_status_reg;
         o_err_cor <= next_err[0];
         o_err_nonfatal <= next_err[1];
         o_err_fatal <= next_err[2];
      end
   end

   // ----------------------------------------
   // Wake and beacon gating
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_wake_sideband_n <= 1'b1;
         o_beacon <= 1'b0;
      end else if (i_ce) begin
         o_wake_sideband_n <= ~(i_wake_req & wake_output_enable);
         o_beacon <= i_beacon_req & beacon_enable;
      end
   end

   // ----------------------------------------
   // Interrupts: bit n = rise of status class n
   // ----------------------------------------
   // Set wins over a write-one-to-clear in the same cycle
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         irq_status <= 3'b000;
      end else if (i_ce) begin
         irq_status <= (irq_status & ~(wr_ist ? i_wdata[2:0] : 3'b000)) | status_rise;
      end
   end

   // A mask bit of one hides its status bit from the output
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         irq_mask <= 3'b000;
      end else if (i_ce && wr_imk) begin
         irq_mask <= i_wdata[2:0];
      end
   end

   assign o_irq = |(irq_status & ~irq_mask);

   // ----------------------------------------
   // Read path
   // ----------------------------------------
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (i_addr)
         `STW_OFS_REPORT_CTL: begin
            next_rdata[5:0] = {completion_timeout_report_sel,
               nonposted_timeout_report_sel, posted_timeout_report_sel};
         end
         `STW_OFS_DISCARD_CNT: begin
            next_rdata[23:0] = {completion_discard_counter,
               nonposted_discard_counter, posted_discard_counter};
         end
         `STW_OFS_WAKEUP_CTL: begin
            next_rdata[1:0] = {beacon_enable, wake_output_enable};
         end
         `STW_OFS_TIMEOUT_CTL: begin
            next_rdata[0] = timeout_discard_enable;
         end
         `STW_OFS_IRQ_STATUS: begin
            next_rdata[2:0] = irq_status;
         end
         `STW_OFS_IRQ_MASK: begin
            next_rdata[2:0] = irq_mask;
         end
         default: begin
            next_rdata = 32'h0000_0000;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         o_rdata <= 32'h0000_0000;
      end else if (i_ce) begin
         o_rdata <= i_rd ? next_rdata : 32'h0000_0000;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   always_ff @(posedge i_core_clk) begin
      if (!i_resetn) begin
         disc_seen_q <= 3'b000;
      end else begin
         disc_seen_q <= disc_seen;
      end
   end

   a_posted_sel_default: assert property (@(posedge i_core_clk) $rose(i_fund_resetn) |->
      posted_timeout_report_sel == 2'h2) else $error("posted select default wrong");
   a_np_sel_write: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      wr_rep |=> nonposted_timeout_report_sel == $past(i_wdata[3:2])) else $error("np select not written");
   a_cpl_sel_write: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      wr_rep |=> completion_timeout_report_sel == $past(i_wdata[5:4])) else $error("cpl select not written");
   a_report_on_rise: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && status_rise == 3'b000 |=> !o_err_cor && !o_err_nonfatal && !o_err_fatal)
      else $error("report while status held");
   a_fatal_decode: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && status_rise == 3'b001 && posted_timeout_report_sel == 2'h3 |=> o_err_fatal && !o_err_cor)
      else $error("fatal decode wrong");
   a_posted_count: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      i_ce && disc_seen[0] && !cnt_read && posted_discard_counter < 8'hFF |=>
      posted_discard_counter == $past(posted_discard_counter) + 8'h01) else $error("posted count");
   a_np_count: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      i_ce && disc_seen[1] && !cnt_read && nonposted_discard_counter < 8'hFF |=>
      nonposted_discard_counter == $past(nonposted_discard_counter) + 8'h01) else $error("np count");
   a_cpl_count: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      i_ce && disc_seen[2] && !cnt_read && completion_discard_counter < 8'hFF |=>
      completion_discard_counter == $past(completion_discard_counter) + 8'h01) else $error("cpl count");
   a_count_saturate: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      posted_discard_counter == 8'hFF && !cnt_read |=> posted_discard_counter == 8'hFF)
      else $error("counter wrapped");
   a_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn || !i_resetn)
      cnt_read |=> o_rdata[7:0] == $past(posted_discard_counter) &&
      posted_discard_counter == {7'h00, disc_seen_q[0]}) else $error("read clear");
   a_wake_gated: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && !wake_output_enable |=> o_wake_sideband_n) else $error("wake not gated");
   a_beacon_gated: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && !beacon_enable |=> !o_beacon) else $error("beacon not gated");
   a_discard_gate: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      !timeout_discard_enable |-> disc_seen == 3'b000) else $error("discard counted while off");
   a_sticky_hold: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      !i_resetn && !wr_wake |=> wake_output_enable == $past(wake_output_enable))
      else $error("sticky lost on reset");

   // ----------------------------------------
   // Further checks on defaults, select write, decode and freeze
   // ----------------------------------------
   a_np_sel_default: assert property (@(posedge i_core_clk) $rose(i_fund_resetn) |->
      nonposted_timeout_report_sel == 2'h0) else $error("np select default wrong");
   a_cpl_sel_default: assert property (@(posedge i_core_clk) $rose(i_fund_resetn) |->
      completion_timeout_report_sel == 2'h0) else $error("cpl select default wrong");
   a_posted_sel_write: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      wr_rep |=> posted_timeout_report_sel == $past(i_wdata[1:0])) else $error("posted select not written");
   a_wake_default: assert property (@(posedge i_core_clk) $rose(i_fund_resetn) |->
      wake_output_enable) else $error("wake enable default wrong");
   a_beacon_default: assert property (@(posedge i_core_clk) $rose(i_fund_resetn) |->
      beacon_enable) else $error("beacon enable default wrong");
   a_cor_decode: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && status_rise == 3'b001 && posted_timeout_report_sel == 2'h1 |=> o_err_cor && !o_err_fatal)
      else $error("correctable decode wrong");
   a_nonfatal_decode: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && status_rise == 3'b001 && posted_timeout_report_sel == 2'h2 |=> o_err_nonfatal && !o_err_cor)
      else $error("nonfatal decode wrong");
   a_none_decode: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && status_rise == 3'b001 && posted_timeout_report_sel == 2'h0 |=> !o_err_cor && !o_err_nonfatal)
      else $error("none decode sent a message");
   a_ce_freeze_err: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      !i_ce |=> o_err_fatal == $past(o_err_fatal)) else $error("report moved while frozen");

   // ----------------------------------------
   // Further checks on counters, reserved bits, sticky select hold and interrupt set
   // ----------------------------------------
   a_np_saturate: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      nonposted_discard_counter == 8'hFF && !cnt_read |=> nonposted_discard_counter == 8'hFF)
      else $error("np counter wrapped");
   a_cpl_saturate: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      completion_discard_counter == 8'hFF && !cnt_read |=> completion_discard_counter == 8'hFF)
      else $error("cpl counter wrapped");
   a_np_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn || !i_resetn)
      cnt_read |=> o_rdata[15:8] == $past(nonposted_discard_counter) &&
      nonposted_discard_counter == {7'h00, disc_seen_q[1]}) else $error("np read clear");
   a_cpl_read_clears: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn || !i_resetn)
      cnt_read |=> o_rdata[23:16] == $past(completion_discard_counter) &&
      completion_discard_counter == {7'h00, disc_seen_q[2]}) else $error("cpl read clear");
   a_ce_freeze_cnt: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      !i_ce |=> posted_discard_counter == $past(posted_discard_counter)) else $error("count moved while frozen");
   a_reserved_zero: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && i_rd && i_addr == `STW_OFS_REPORT_CTL |=> o_rdata[31:6] == 26'h0)
      else $error("reserved bits not zero");
   a_sticky_sel_hold: assert property (@(posedge i_core_clk) disable iff (!i_fund_resetn)
      !i_resetn && !wr_rep |=> posted_timeout_report_sel == $past(posted_timeout_report_sel))
      else $error("report select lost on reset");
   a_irq_set: assert property (@(posedge i_core_clk) disable iff (!i_resetn)
      i_ce && status_rise[0] |=> irq_status[0]) else $error("irq status not set");

endmodule
`default_nettype wire

// File: logic/stw_cfg.svh
// Operation
// - Bits 1:0 of report control select posted time-out report, default 0x2.
// - Bits 3:2 select non-posted time-out report, default 0x0.
// - Bits 5:4 select completion time-out report, default 0x0.
// - Report a class only on its status bit rising from zero to one.
// - Decode 0 none, 1 correctable, 2 nonfatal, 3 fatal message.
// - Count bits 7:0 increment per posted queue time-out discard.
// - Count bits 15:8 increment per non-posted queue time-out discard.
// - Count bits 23:16 increment per completion queue time-out discard.
// - Counters saturate at all ones, never wrap.
// - Reading a counter returns its value then clears it.
// - Wakeup bit 0, default 1, gates the wake sideband output.
// - Wakeup bit 1, default 1, gates in-band beacon signalling.
// - With time-out enable set, discard packets older than the time-out limit. The code exports it as o_timeout_discard_enable and gates discard counting.
`ifndef STW_CFG_SVH
`define STW_CFG_SVH
`define STW_ADDR_W 12
`define STW_OFS_REPORT_CTL 12'h4E8
`define STW_OFS_DISCARD_CNT 12'h4EC
`define STW_OFS_WAKEUP_CTL 12'h5CC
`define STW_OFS_TIMEOUT_CTL 12'h4E4
`define STW_OFS_IRQ_STATUS 12'h4F0
`define STW_OFS_IRQ_MASK 12'h4F4
`define STW_RST_POSTED_SEL 2'h2
`define STW_RST_NONPOSTED_SEL 2'h0
`define STW_RST_COMPL_SEL 2'h0
`define STW_RST_WAKE_EN 1'h1
`define STW_RST_BEACON_EN 1'h1
`define STW_RST_TO_EN 1'h1
`define STW_CNT_MAX 8'hFF
`endif

// File: logic/stw_pkg.sv
package stw_pkg;
   typedef enum logic [1:0] {
      STW_REP_NONE = 2'b00,
      STW_REP_COR = 2'b01,
      STW_REP_NONFATAL = 2'b10,
      STW_REP_FATAL = 2'b11
   } stw_report_e;
   typedef logic [7:0] stw_count_t;
endpackage

// File: sim/stw_root_model.sv
`timescale 1ns/1ns
`default_nettype none
module stw_root_model (
   input wire logic i_core_clk,
   input wire logic i_err_cor,
   input wire logic i_err_nonfatal,
   input wire logic i_err_fatal,
   output int o_n_cor,
   output int o_n_nonfatal,
   output int o_n_fatal
);
   // ----------------------------------------
   // Message intake
   // ----------------------------------------
   // Every high cycle is one message, so a stretched pulse shows as extra messages
   initial begin
      o_n_cor = 0;
      o_n_nonfatal = 0;
      o_n_fatal = 0;
   end
   always @(posedge i_core_clk) begin
      o_n_cor <= o_n_cor + int'(i_err_cor);
      o_n_nonfatal <= o_n_nonfatal + int'(i_err_nonfatal);
      o_n_fatal <= o_n_fatal + int'(i_err_fatal);
   end
endmodule
`default_nettype wire

// File: sim/stw_timeout_ctl_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`include "stw_cfg.svh"
module stw_timeout_ctl_tb_top;
   logic clk = 0, rstn = 0, frstn = 0, ce = 1, wr = 0, rd = 0, wreq = 0, breq = 0;
   logic [11:0] addr = 12'h000;
   logic [31:0] wdata = 32'h0, rdata;
   logic [2:0] sts = 3'h0, disc = 3'h0;
   logic ten, ecor, enf, efat, wake_n, beacon, irq;
   int n_cor, n_nf, n_fat, n_errors = 0, checks_done = 0;
   always #4 clk = ~clk;
   stw_timeout_ctl u_dut (.i_core_clk(clk), .i_resetn(rstn), .i_fund_resetn(frstn), .i_ce(ce),
      .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata),
      .i_timeout_status_reg(sts), .i_discard(disc), .i_wake_req(wreq), .i_beacon_req(breq),
      .o_timeout_discard_enable(ten), .o_err_cor(ecor), .o_err_nonfatal(enf), .o_err_fatal(efat),
      .o_wake_sideband_n(wake_n), .o_beacon(beacon), .o_irq(irq));
   stw_root_model u_root (.i_core_clk(clk), .i_err_cor(ecor), .i_err_nonfatal(enf),
      .i_err_fatal(efat), .o_n_cor(n_cor), .o_n_nonfatal(n_nf), .o_n_fatal(n_fat));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
      @(posedge clk) begin wr <= 1'b1; addr <= a; wdata <= d; end
      @(posedge clk) wr <= 1'b0;
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
      @(posedge clk) begin rd <= 1'b1; addr <= a; end
      @(posedge clk) rd <= 1'b0;
      #1 check(rdata, exp);
   endtask
   task automatic pulse(input logic [2:0] d, input int n);
      repeat (n) begin
         @(posedge clk) disc <= d;
         @(posedge clk) disc <= 3'h0;
      end
   endtask
   task automatic do_reset(input logic fund);
      @(posedge clk) begin rstn <= 1'b0; frstn <= ~fund; end
      cyc(2);
      @(posedge clk) begin rstn <= 1'b1; frstn <= 1'b1; end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_defaults();
      rd_reg(`STW_OFS_REPORT_CTL, 32'h0000_0002);
      rd_reg(`STW_OFS_WAKEUP_CTL, 32'h0000_0003);
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h0);
      rd_reg(12'h100, 32'h0);
      check(ten, 1'b1);
   endtask
   task automatic t_report();
      int b[3];
      for (int c = 0; c < 3; c++) begin
         for (int s = 0; s < 4; s++) begin
            wr_reg(`STW_OFS_REPORT_CTL, 32'(s) << (2 * c));
            b = '{n_cor, n_nf, n_fat};
            @(posedge clk) sts <= 3'(1 << c);
            cyc(5);
            check(32'(n_cor - b[0]), 32'(s == 1));
            check(32'(n_nf - b[1]), 32'(s == 2));
            check(32'(n_fat - b[2]), 32'(s == 3));
            @(posedge clk) sts <= 3'h0;
         end
      end
   endtask
   task automatic t_count();
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h0);
      pulse(3'b001, 3);
      pulse(3'b010, 5);
      pulse(3'b100, 7);
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h0007_0503);
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h0);
      pulse(3'b111, 260);
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h00FF_FFFF);
      wr_reg(`STW_OFS_TIMEOUT_CTL, 32'h0);
      #1 check(ten, 1'b0);
      pulse(3'b111, 2);
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h0);
      wr_reg(`STW_OFS_TIMEOUT_CTL, 32'h1);
      @(posedge clk) ce <= 1'b0;
      pulse(3'b001, 2);
      @(posedge clk) ce <= 1'b1;
      rd_reg(`STW_OFS_DISCARD_CNT, 32'h0);
   endtask
   task automatic t_wake();
      @(posedge clk) begin wreq <= 1'b1; breq <= 1'b1; end
      cyc(3);
      #1 check({wake_n, beacon}, 2'b01);
      wr_reg(`STW_OFS_WAKEUP_CTL, 32'h2);
      cyc(2);
      #1 check({wake_n, beacon}, 2'b11);
      wr_reg(`STW_OFS_WAKEUP_CTL, 32'h1);
      cyc(2);
      #1 check({wake_n, beacon}, 2'b00);
      @(posedge clk) begin wreq <= 1'b0; breq <= 1'b0; end
   endtask
   task automatic t_sticky();
      wr_reg(`STW_OFS_REPORT_CTL, 32'hFFFF_FFFF);
      rd_reg(`STW_OFS_REPORT_CTL, 32'h0000_003F);
      wr_reg(`STW_OFS_WAKEUP_CTL, 32'hFFFF_FFFC);
      do_reset(1'b0);
      rd_reg(`STW_OFS_REPORT_CTL, 32'h0000_003F);
      rd_reg(`STW_OFS_WAKEUP_CTL, 32'h0);
      do_reset(1'b1);
      rd_reg(`STW_OFS_REPORT_CTL, 32'h0000_0002);
      rd_reg(`STW_OFS_WAKEUP_CTL, 32'h0000_0003);
   endtask
   task automatic t_irq();
      wr_reg(`STW_OFS_IRQ_MASK, 32'h0);
      wr_reg(`STW_OFS_IRQ_STATUS, 32'h7);
      @(posedge clk) sts <= 3'b001;
      cyc(3);
      check(irq, 1'b1);
      rd_reg(`STW_OFS_IRQ_STATUS, 32'h1);
      wr_reg(`STW_OFS_IRQ_MASK, 32'h1);
      #1 check(irq, 1'b0);
      wr_reg(`STW_OFS_IRQ_MASK, 32'h0);
      wr_reg(`STW_OFS_IRQ_STATUS, 32'h1);
      #1 check(irq, 1'b0);
      @(posedge clk) sts <= 3'h0;
   endtask
   // ----------------------------------------
   // Run control
   // ----------------------------------------
   task automatic summarize();
      $display("checks %0d errors %0d", checks_done, n_errors);
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      #400000;
      n_errors++;
      summarize();
   end
   initial begin
      cyc(2);
      @(posedge clk) begin rstn <= 1'b1; frstn <= 1'b1; end
      t_defaults();
      t_report();
      t_count();
      t_wake();
      t_sticky();
      t_irq();
      summarize();
   end
endmodule
`default_nettype wire
